// ### logic/alert_mask_params.svh
`ifndef ALERT_MASK_PARAMS_SVH
`define ALERT_MASK_PARAMS_SVH

`define CMD_ALERT_MASK 8'h1B
`define PAGE_ALL_PHASES 8'hFF
`define SEL_OUT_VOLT 8'h7A
`define SEL_OUT_CURR 8'h7B
`define SEL_INPUT 8'h7C
`define SEL_THERMAL 8'h7D
`define WR_BITS_OUT_VOLT 8'hFC
`define WR_BITS_OUT_CURR 8'hB0
`define WR_BITS_INPUT 8'hE8
`define WR_BITS_THERMAL 8'hC0
`define MASK_RESET 8'h00
`define NUM_CATEGORIES 4

`endif

// ### logic/alert_mask_pkg.sv
`default_nettype none
package alert_mask_pkg;
  typedef logic [7:0] mask_byte_t;
  typedef enum logic [1:0] {
    CAT_OUT_VOLT = 2'b00,
    CAT_OUT_CURR = 2'b01,
    CAT_INPUT = 2'b10,
    CAT_THERMAL = 2'b11
  } category_t;
endpackage
`default_nettype wire

// ### logic/alert_source_mask_bank.sv
// How it works
// - Output-voltage mask is command 1Bh with selector 7Ah.
// - Output-current mask is command 1Bh with selector 7Bh.
// - Input mask is command 1Bh with selector 7Ch.
// - Temperature mask is command 1Bh with selector 7Dh.
// - Write word: selector in low byte, new mask in high byte.
// - Process-call read returns the one selected mask byte.
// - Mask bit 0 lets its condition raise alert; 1 blocks it.
// - Mask commands accepted only while page is FFh.
// - Writes act at once; reset clears masks, non-volatile copy loaded on first edge after release.
// - Output-voltage mask bits 1:0 read zero, writes ignored there.
// - Masking never stops status bits setting; only alert contribution.
`timescale 1ns/10ps
`default_nettype none
`include "alert_mask_params.svh"
module alert_source_mask_bank
  import alert_mask_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] page,
  input wire logic txn_valid,
  input wire logic txn_is_read,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] selector,
  input wire logic [7:0] wr_mask,
  input wire logic [7:0] nvm_out_volt,
  input wire logic [7:0] nvm_out_curr,
  input wire logic [7:0] nvm_input,
  input wire logic [7:0] nvm_thermal,
  input wire logic [7:0] output_voltage_flags,
  input wire logic [7:0] output_current_flags,
  input wire logic [7:0] input_flags,
  input wire logic [7:0] thermal_flags,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic txn_refused,
  output logic alert_n
);
  localparam mask_byte_t SEL_CODE [`NUM_CATEGORIES] = '{
    `SEL_OUT_VOLT, `SEL_OUT_CURR, `SEL_INPUT, `SEL_THERMAL};
  localparam mask_byte_t WR_BITS [`NUM_CATEGORIES] = '{
    `WR_BITS_OUT_VOLT, `WR_BITS_OUT_CURR, `WR_BITS_INPUT,
    `WR_BITS_THERMAL};

  mask_byte_t mask [`NUM_CATEGORIES];
  mask_byte_t nvm_val [`NUM_CATEGORIES];
  mask_byte_t flags [`NUM_CATEGORIES];
  logic [`NUM_CATEGORIES-1:0] sel_hit;
  logic [`NUM_CATEGORIES-1:0] unmasked_hit;
  logic load_pending;
  logic cmd_hit;
  logic page_ok;
  logic mask_write;
  logic rd_accept;
  mask_byte_t next_rd_data;

  assign nvm_val[CAT_OUT_VOLT] = nvm_out_volt;
  assign nvm_val[CAT_OUT_CURR] = nvm_out_curr;
  assign nvm_val[CAT_INPUT] = nvm_input;
  assign nvm_val[CAT_THERMAL] = nvm_thermal;
  assign flags[CAT_OUT_VOLT] = output_voltage_flags;
  assign flags[CAT_OUT_CURR] = output_current_flags;
  assign flags[CAT_INPUT] = input_flags;
  assign flags[CAT_THERMAL] = thermal_flags;

  assign cmd_hit = txn_valid && (cmd_code == `CMD_ALERT_MASK);
  assign page_ok = (page == `PAGE_ALL_PHASES);
  assign mask_write = cmd_hit && page_ok && !txn_is_read && !load_pending;
  assign rd_accept = cmd_hit && page_ok && txn_is_read && (|sel_hit)
    && !load_pending;

  // Reset may only load constants, so the stored copy follows one edge later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CATEGORIES; gi++) begin : g_cat
      assign sel_hit[gi] = (selector == SEL_CODE[gi]);
      // Status inputs are never altered here, only gated
      assign unmasked_hit[gi] = |(flags[gi] & ~mask[gi]);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mask[gi] <= `MASK_RESET;
        end else if (load_pending) begin
          mask[gi] <= nvm_val[gi] & WR_BITS[gi];
        end else if (mask_write && sel_hit[gi]) begin
          mask[gi] <= wr_mask & WR_BITS[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    next_rd_data = `MASK_RESET;
    for (int i = 0; i < `NUM_CATEGORIES; i++) begin
      if (sel_hit[i]) begin
        next_rd_data = mask[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= `MASK_RESET;
    end else begin
      rd_valid <= rd_accept;
      // A refused read leaves the last answer standing
      if (rd_accept) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // Other pages or unknown selectors are refused, masks untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txn_refused <= 1'b0;
    end else begin
      txn_refused <= cmd_hit && (!page_ok || !(|sel_hit) || load_pending);
    end
  end

  // Held inactive until the stored masks are in place
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= load_pending || !(|unmasked_hit);
    end
  end

  AST_WR_OUT_VOLT: assert property (@(posedge clk) disable iff (!rst_n)
    mask_write && selector == 8'h7A |=> mask[0] == ($past(wr_mask) & 8'hFC))
    else $error("output voltage mask write lost");
  AST_WR_OUT_CURR: assert property (@(posedge clk) disable iff (!rst_n)
    mask_write && selector == 8'h7B |=> mask[1] == ($past(wr_mask) & 8'hB0))
    else $error("output current mask write lost");
  AST_WR_INPUT: assert property (@(posedge clk) disable iff (!rst_n)
    mask_write && selector == 8'h7C |=> mask[2] == ($past(wr_mask) & 8'hE8))
    else $error("input mask write lost");
  AST_WR_THERMAL: assert property (@(posedge clk) disable iff (!rst_n)
    mask_write && selector == 8'h7D |=> mask[3] == ($past(wr_mask) & 8'hC0))
    else $error("thermal mask write lost");
  AST_READ_BACK: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_hit && txn_is_read && page_ok && selector == 8'h7B && !load_pending
    |=> rd_valid && rd_data == $past(mask[1]))
    else $error("read did not return selected mask");
  AST_PAGE_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_hit && page != 8'hFF |=> txn_refused && !rd_valid
    && $stable(mask[0]) && $stable(mask[3]))
    else $error("mask command accepted on other page");
  AST_ALERT_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    !load_pending && ((thermal_flags & ~mask[3]) != 8'h00
    || (output_voltage_flags & ~mask[0]) != 8'h00
    || (output_current_flags & ~mask[1]) != 8'h00
    || (input_flags & ~mask[2]) != 8'h00) |=> !alert_n)
    else $error("alert output does not follow unmasked flags");
  AST_MASK_BLOCKS: assert property (@(posedge clk) disable iff (!rst_n)
    !load_pending && (thermal_flags & ~mask[3]) == 8'h00
    && (output_voltage_flags & ~mask[0]) == 8'h00
    && (output_current_flags & ~mask[1]) == 8'h00
    && (input_flags & ~mask[2]) == 8'h00 |=> alert_n)
    else $error("masked condition raised alert");
  // Release edge itself is skipped; the load lands one edge later
  AST_NVM_RESTORE: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && load_pending |=> !load_pending
    && mask[0] == ($past(nvm_out_volt) & 8'hFC)
    && mask[1] == ($past(nvm_out_curr) & 8'hB0)
    && mask[2] == ($past(nvm_input) & 8'hE8)
    && mask[3] == ($past(nvm_thermal) & 8'hC0))
    else $error("mask not restored from stored copy");
  AST_VOLT_LOW_ZERO: assert property (@(posedge clk)
    disable iff (!rst_n) mask[0][1:0] == 2'b00)
    else $error("output voltage mask low bits not zero");
  AST_UNSUPP_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (mask[1] & 8'h4F) == 8'h00 && (mask[2] & 8'h17) == 8'h00
    && (mask[3] & 8'h3F) == 8'h00)
    else $error("unsupported mask bit set");
  // Read answers, refusals and command gating; alert held inactive during load
  AST_RD_OUT_VOLT: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_hit && txn_is_read && page_ok && selector == 8'h7A && !load_pending
    |=> rd_valid && rd_data == $past(mask[0]) && rd_data[1:0] == 2'b00)
    else $error("read did not return output voltage mask");
  AST_RD_INPUT: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_hit && txn_is_read && page_ok && selector == 8'h7C && !load_pending
    |=> rd_valid && rd_data == $past(mask[2]))
    else $error("read did not return input mask");
  AST_RD_THERMAL: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_hit && txn_is_read && page_ok && selector == 8'h7D && !load_pending
    |=> rd_valid && rd_data == $past(mask[3]))
    else $error("read did not return thermal mask");
  AST_RD_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_hit && txn_is_read && !load_pending |=> $stable(mask[0])
    && $stable(mask[1]) && $stable(mask[2]) && $stable(mask[3]))
    else $error("read changed a mask");
  AST_WR_NO_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
    txn_valid && !txn_is_read |=> !rd_valid)
    else $error("write produced a read answer");
  AST_RD_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_valid |-> $stable(rd_data))
    else $error("read data changed without an answer");
  AST_REFUSE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    !cmd_hit |=> !txn_refused && !rd_valid)
    else $error("answer without a mask command");
  AST_PAGE_READ: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_hit && txn_is_read && page != 8'hFF |=> txn_refused && !rd_valid
    && $stable(rd_data))
    else $error("read answered on other page");
  AST_OTHER_CMD: assert property (@(posedge clk) disable iff (!rst_n)
    txn_valid && cmd_code != 8'h1B && !load_pending |=> !txn_refused
    && $stable(mask[0]) && $stable(mask[1]) && $stable(mask[2])
    && $stable(mask[3]))
    else $error("other command touched the masks");
  AST_BAD_SEL: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_hit && (selector < 8'h7A || selector > 8'h7D) |=> txn_refused
    && !rd_valid)
    else $error("unknown selector accepted");
  AST_LOAD_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    load_pending |=> alert_n)
    else $error("alert raised before masks were restored");
endmodule
`default_nettype wire

// ### tb/pmbus_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmbus_host_model (
  input wire logic clk,
  output logic txn_valid,
  output logic txn_is_read,
  output logic [7:0] cmd_code,
  output logic [7:0] selector,
  output logic [7:0] wr_mask
);
  initial begin
    txn_valid = 1'b0;
    txn_is_read = 1'b0;
    cmd_code = 8'h00;
    selector = 8'h00;
    wr_mask = 8'h00;
  end
  // Read: selector block then one byte back; write: low sel, high mask
  task automatic xfer_cmd(input logic [7:0] cmd, input logic rd,
    input logic [7:0] sel, msk);
    @(posedge clk);
    txn_valid <= 1'b1;
    txn_is_read <= rd;
    cmd_code <= cmd;
    selector <= sel;
    wr_mask <= msk;
    @(posedge clk);
    txn_valid <= 1'b0;
    // Released bytes must not keep the last value
    cmd_code <= ~cmd;
    wr_mask <= ~msk;
    selector <= ~sel;
  endtask
  task automatic xfer(input logic rd, input logic [7:0] sel, msk);
    xfer_cmd(8'h1B, rd, sel, msk);
  endtask
endmodule
`default_nettype wire

// ### tb/alert_source_mask_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module alert_source_mask_bank_tb_top;
  import alert_mask_pkg::*;
  localparam logic [7:0] SEL [4] = '{8'h7A, 8'h7B, 8'h7C, 8'h7D};
  localparam logic [7:0] WB [4] = '{8'hFC, 8'hB0, 8'hE8, 8'hC0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] page = 8'hFF;
  mask_byte_t flg [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  mask_byte_t nvm [4] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
  wire logic tv, tr, rv, rf, alert_n;
  wire logic [7:0] cc, sl, wm, rd;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  pmbus_host_model i_host (.clk(clk), .txn_valid(tv), .txn_is_read(tr),
    .cmd_code(cc), .selector(sl), .wr_mask(wm));
  alert_source_mask_bank i_dut (.clk(clk), .rst_n(rst_n), .page(page),
    .txn_valid(tv), .txn_is_read(tr), .cmd_code(cc), .selector(sl),
    .wr_mask(wm), .nvm_out_volt(nvm[0]), .nvm_out_curr(nvm[1]),
    .nvm_input(nvm[2]), .nvm_thermal(nvm[3]),
    .output_voltage_flags(flg[0]), .output_current_flags(flg[1]),
    .input_flags(flg[2]), .thermal_flags(flg[3]), .rd_valid(rv),
    .rd_data(rd), .txn_refused(rf), .alert_n(alert_n));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input int i, input logic [7:0] exp);
    i_host.xfer(1'b1, SEL[i], 8'h00);
    #1;
    chk({7'h00, rv}, 8'h01);
    chk(rd, exp);
  endtask
  task automatic alert_chk(input int i, input logic [7:0] f, input logic e);
    @(posedge clk);
    flg[i] <= f;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, alert_n}, {7'h00, e});
    @(posedge clk);
    flg[i] <= 8'h00;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, alert_n}, 8'h01);
  endtask
  task automatic refuse_chk(input logic [7:0] pg, cmd, input logic r,
    input logic [7:0] sel, input logic exp);
    @(posedge clk);
    page <= pg;
    i_host.xfer_cmd(cmd, r, sel, 8'h00);
    #1;
    chk({6'h00, rv, rf}, {7'h00, exp});
    @(posedge clk);
    page <= 8'hFF;
  endtask
  task automatic reset_chk();
    @(posedge clk);
    rst_n <= 1'b0;
    nvm <= '{8'h5A, 8'hA5, 8'h3C, 8'h96};
    flg[0] <= 8'h04;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({7'h00, alert_n}, 8'h01);
    @(posedge clk);
    #1;
    chk({7'h00, alert_n}, 8'h00);
    for (int i = 0; i < 4; i++) rd_chk(i, nvm[i] & WB[i]);
    @(posedge clk);
    flg[0] <= 8'h00;
    $display("test reset_restore done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Masks restored, unsupported bits read zero
    for (int i = 0; i < 4; i++) rd_chk(i, WB[i]);
    $display("test nvm_restore done");
    // Wrong page, unknown selector, other command: nothing stored
    refuse_chk(8'h00, 8'h1B, 1'b0, SEL[0], 1'b1);
    refuse_chk(8'h00, 8'h1B, 1'b1, SEL[0], 1'b1);
    refuse_chk(8'hFF, 8'h1B, 1'b0, 8'h7E, 1'b1);
    refuse_chk(8'hFF, 8'h1C, 1'b0, SEL[0], 1'b0);
    rd_chk(0, WB[0]);
    $display("test refusal done");
    for (int i = 0; i < 4; i++) begin
      i_host.xfer(1'b0, SEL[i], 8'h00);
      rd_chk(i, 8'h00);
      i_host.xfer(1'b0, SEL[i], 8'hFF);
      rd_chk(i, WB[i]);
      i_host.xfer(1'b0, SEL[i], 8'h00);
    end
    $display("test write_read done");
    for (int i = 0; i < 4; i++) alert_chk(i, WB[i], 1'b0);
    i_host.xfer(1'b0, SEL[3], 8'hFF);
    rd_chk(3, WB[3]);
    alert_chk(3, 8'hC0, 1'b1);
    // Unsupported positions are never gated
    alert_chk(3, 8'h01, 1'b0);
    $display("test alert done");
    reset_chk();
    results();
  end
endmodule
`default_nettype wire
